/* File: core/rx_done_queue_burst_dma.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_done_queue_burst_dma #(
    parameter int DEPTH = 8,
    parameter int WATERMARK = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Completed descriptor from the receive engine
    input wire rx_done_pkg::done_req_s doneReq,
    input wire logic doneValid,
    output logic doneReady,
    // Buffer fill events from the receive engine
    input wire logic [5:0] fillChannel,
    input wire logic fillBufferDone,
    input wire logic fillPacketEnd,
    input wire logic [31:0] fillNextAddr,
    input wire logic [15:0] fillNextDesc,
    // Per-channel view for the receive engine
    input wire logic [5:0] viewChannel,
    output logic viewEnable,
    output logic viewUseSmall,
    output logic [31:0] viewStartAddr,
    // Memory write port toward the PCI master
    output rx_done_pkg::mem_wr_s memWr,
    input wire logic memReady,
    // Status flags
    output logic doneWriteFlag,
    output logic doneWriteErrorFlag
);
    import rx_done_pkg::*;

    if (DEPTH > FIFO_DEPTH || DEPTH < 2 || WATERMARK >= DEPTH || WATERMARK < 1) begin
        $error("rx_done_queue_burst_dma: unsupported DEPTH/WATERMARK");
    end

    localparam int PW = $clog2(DEPTH);

    typedef enum {S_IDLE, S_CHECK, S_WRITE} wr_state_e;

    // Host registers
    logic [15:0] base0_ff, base1_ff, endAddr_ff, rdPtr_ff, wrPtr_ff;
    logic [15:0] timerReload_ff, queueCtrl_ff;
    logic [15:0] chanSel_ff, chanData_ff;
    logic writeFlag_ff, errorFlag_ff;

    // Done FIFO
    logic [31:0] fifoMem [DEPTH];
    logic [PW-1:0] head_ff, tail_ff;
    logic [PW:0] count_ff;

    // Writer
    wr_state_e state_ff;
    logic [PW:0] burstLeft_ff;
    logic [15:0] timer_ff;
    logic [7:0] prescale_ff;
    logic [7:0] statusCount_ff;

    // Configuration RAM: dword0 address, dword1 {start, current}, dword2 host word
    logic [31:0] cfgAddr [NUM_CHANNELS];
    logic [31:0] cfgDesc [NUM_CHANNELS];
    logic [15:0] cfgHost [NUM_CHANNELS];
    logic [2:0] cfgThrCnt [NUM_CHANNELS];

    logic burstOn, flushOn, fifoFull, fifoEmpty, tick, timerExpired;
    logic [15:0] nextWr, room;
    logic doWrite, pushFifo, popFifo, directWrite;
    logic [31:0] entry, fifoHead;
    logic busWrite_ff, busRead;
    logic [11:0] busAddr_ff;
    logic [2:0] statusThr;
    logic [8:0] statusTarget;

    assign burstOn = queueCtrl_ff[CTRL_BURST_BIT];
    assign flushOn = queueCtrl_ff[CTRL_FLUSH_BIT];
    assign statusThr = queueCtrl_ff[CTRL_THR_LSB +: 3];
    assign statusTarget = 9'(1) << statusThr;
    assign fifoFull = (count_ff == (PW+1)'(DEPTH));
    assign fifoEmpty = (count_ff == '0);
    assign fifoHead = fifoMem[head_ff];

    // Descriptor word: V=0, EOF and status left to the packet engine
    assign entry = {10'h000, doneReq.channel, doneReq.descPtr};

    // wrap when the advanced pointer would pass the end address
    assign nextWr = (wrPtr_ff + 16'h0001 > endAddr_ff) ? 16'h0000 : wrPtr_ff + 16'h0001;
    assign room = (rdPtr_ff > wrPtr_ff) ? (rdPtr_ff - wrPtr_ff - 16'h0001) :
                  (endAddr_ff - wrPtr_ff + rdPtr_ff);
    assign tick = (prescale_ff == 8'(PRESCALE - 1));
    assign timerExpired = burstOn && (timer_ff == 16'h0000);

    // Single mode still queues each descriptor in the FIFO; the writer drains it as soon as it is not empty
    assign directWrite = !burstOn && !flushOn && fifoEmpty;
    assign doneReady = (state_ff == S_IDLE) && !fifoFull && !directWrite ? 1'b1 :
                       (state_ff == S_IDLE) && directWrite;
    assign pushFifo = doneValid && doneReady;
    assign doWrite = (state_ff == S_WRITE) && memReady;
    assign popFifo = doWrite;

    // AHB-Lite: zero-wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign busRead = hsel && hready && htrans[1] && !hwrite;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busWrite_ff <= 1'b0;
            busAddr_ff <= '0;
        end else if (hready) begin
            busWrite_ff <= hsel && htrans[1] && hwrite && (hsize == 3'b010);
            busAddr_ff <= haddr;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= '0;
        end else if (busRead) begin
            case (haddr)
                ADDR_BASE0: hrdata <= {16'h0000, base0_ff};
                ADDR_BASE1: hrdata <= {16'h0000, base1_ff};
                ADDR_END: hrdata <= {16'h0000, endAddr_ff};
                ADDR_RDPTR: hrdata <= {16'h0000, rdPtr_ff};
                ADDR_WRPTR: hrdata <= {16'h0000, wrPtr_ff};
                ADDR_FLUSH_TIMER: hrdata <= {16'h0000, timerReload_ff};
                ADDR_CHAN_SEL: hrdata <= {16'h0000, chanSel_ff};
                ADDR_CHAN_DATA: hrdata <= {16'h0000, chanData_ff};
                ADDR_QUEUE_CTRL: hrdata <= {16'h0000, queueCtrl_ff};
                ADDR_DMA_STATUS: hrdata <= {30'h0000_0000, errorFlag_ff, writeFlag_ff};
                default: hrdata <= '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            base0_ff <= '0;
            base1_ff <= '0;
            endAddr_ff <= '0;
            rdPtr_ff <= '0;
            timerReload_ff <= TIMER_RESET;
            queueCtrl_ff <= CTRL_RESET;
            chanSel_ff <= '0;
        end else if (busWrite_ff) begin
            case (busAddr_ff)
                ADDR_BASE0: base0_ff <= hwdata[15:0];
                ADDR_BASE1: base1_ff <= hwdata[15:0];
                ADDR_END: endAddr_ff <= hwdata[15:0];
                ADDR_RDPTR: rdPtr_ff <= hwdata[15:0];
                ADDR_FLUSH_TIMER: timerReload_ff <= hwdata[15:0];
                ADDR_CHAN_SEL: chanSel_ff <= hwdata[15:0] & 16'h073F;
                ADDR_QUEUE_CTRL: queueCtrl_ff <= hwdata[15:0] & CTRL_WMASK;
                default: ;
            endcase
        end
    end

    // Configuration data window: host writes land only in dword2 low (word select 100)
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chanData_ff <= '0;
        end else if (busWrite_ff && busAddr_ff == ADDR_CHAN_DATA) begin
            chanData_ff <= hwdata[15:0];
        end else if (chanSel_ff[5:0] < 6'(NUM_CHANNELS)) begin
            case (chanSel_ff[10:8])
                3'b000: chanData_ff <= cfgAddr[chanSel_ff[5:0]][15:0];
                3'b001: chanData_ff <= cfgAddr[chanSel_ff[5:0]][31:16];
                3'b010: chanData_ff <= cfgDesc[chanSel_ff[5:0]][15:0];
                3'b011: chanData_ff <= cfgDesc[chanSel_ff[5:0]][31:16];
                3'b100: chanData_ff <= cfgHost[chanSel_ff[5:0]];
                3'b101: chanData_ff <= {cfgThrCnt[chanSel_ff[5:0]], 13'h0000};
                default: chanData_ff <= '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (busWrite_ff && busAddr_ff == ADDR_CHAN_DATA && chanSel_ff[10:8] == 3'b100
            && chanSel_ff[5:0] < 6'(NUM_CHANNELS)) begin
            // reserved bits dropped; FBF kept by hardware
            cfgHost[chanSel_ff[5:0]] <= (hwdata[15:0] & CFG_HOST_MASK) |
                (cfgHost[chanSel_ff[5:0]] & 16'h8000);
        end else if (fillBufferDone && fillChannel < 6'(NUM_CHANNELS)) begin
            cfgHost[fillChannel][FBF_BIT] <= fillPacketEnd;
        end
    end

    // per-channel buffer address, descriptor offsets and fill count
    always_ff @(posedge clk) begin
        if (fillBufferDone && fillChannel < 6'(NUM_CHANNELS)) begin
            cfgAddr[fillChannel] <= fillNextAddr;
            cfgDesc[fillChannel][15:0] <= fillNextDesc;
            if (fillPacketEnd || cfgThrCnt[fillChannel] + 3'd1 == cfgHost[fillChannel][9:7]) begin
                cfgDesc[fillChannel][31:16] <= fillNextDesc;
                cfgThrCnt[fillChannel] <= 3'd0;
            end else begin
                cfgThrCnt[fillChannel] <= cfgThrCnt[fillChannel] + 3'd1;
            end
        end
    end

    // policy view for the receive engine
    always_comb begin
        viewEnable = 1'b0;
        viewUseSmall = 1'b0;
        viewStartAddr = '0;
        if (viewChannel < 6'(NUM_CHANNELS)) begin
            viewEnable = cfgHost[viewChannel][0];
            case (buf_sel_e'(cfgHost[viewChannel][2:1]))
                BUF_SMALL: viewUseSmall = 1'b1;
                BUF_SMALL_LARGE: viewUseSmall = cfgHost[viewChannel][FBF_BIT];
                default: viewUseSmall = 1'b0;
            endcase
            viewStartAddr = cfgAddr[viewChannel] +
                (cfgHost[viewChannel][FBF_BIT] ? 32'(cfgHost[viewChannel][6:3]) : 32'h0000_0000);
        end
    end

    always_ff @(posedge clk) begin
        if (pushFifo) begin
            fifoMem[tail_ff] <= entry;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            head_ff <= '0;
            tail_ff <= '0;
            count_ff <= '0;
        end else begin
            if (pushFifo) tail_ff <= (tail_ff == PW'(DEPTH - 1)) ? '0 : tail_ff + 1'b1;
            if (popFifo) head_ff <= (head_ff == PW'(DEPTH - 1)) ? '0 : head_ff + 1'b1;
            count_ff <= count_ff + (PW+1)'(pushFifo) - (PW+1)'(popFifo);
        end
    end

    // Writer: check room, then write one word per accepted beat
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= S_IDLE;
            burstLeft_ff <= '0;
        end else begin
            case (state_ff)
                S_IDLE: begin
                    if (!fifoEmpty && (!burstOn || flushOn || timerExpired
                        || count_ff >= (PW+1)'(WATERMARK))) begin
                        state_ff <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (room == 16'h0000) begin
                        state_ff <= S_IDLE;
                    end else begin
                        burstLeft_ff <= (room < 16'(count_ff)) ? (PW+1)'(room) : count_ff;
                        state_ff <= S_WRITE;
                    end
                end
                S_WRITE: begin
                    if (doWrite) begin
                        burstLeft_ff <= burstLeft_ff - 1'b1;
                        if (burstLeft_ff == (PW+1)'(1)) state_ff <= S_IDLE;
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            memWr <= '0;
        end else begin
            memWr.valid <= (state_ff == S_WRITE) && !(doWrite && burstLeft_ff == (PW+1)'(1));
            memWr.addr <= {base1_ff, base0_ff} + (32'(wrPtr_ff) << 2);
            memWr.data <= fifoHead;
            if (state_ff == S_WRITE && doWrite) begin
                memWr.addr <= {base1_ff, base0_ff} + (32'(nextWr) << 2);
                memWr.data <= fifoMem[(head_ff == PW'(DEPTH - 1)) ? '0 : head_ff + 1'b1];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_ff <= '0;
        end else if (doWrite) begin
            wrPtr_ff <= nextWr;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prescale_ff <= '0;
            timer_ff <= TIMER_RESET;
        end else begin
            prescale_ff <= tick ? '0 : prescale_ff + 8'h01;
            if (doWrite || (timerExpired && state_ff == S_IDLE)) begin
                timer_ff <= timerReload_ff;
            end else if (tick && timer_ff != 16'h0000) begin
                timer_ff <= timer_ff - 16'h0001;
            end
        end
    end

    // write flag after 2^n writes; set wins over clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            statusCount_ff <= '0;
            writeFlag_ff <= 1'b0;
        end else begin
            // Clear first, so a set in the same cycle wins
            if (busWrite_ff && busAddr_ff == ADDR_DMA_STATUS
                && hwdata[STATUS_WRITE_BIT]) begin
                writeFlag_ff <= 1'b0;
            end
            if (doWrite) begin
                if (9'(statusCount_ff) + 9'd1 >= statusTarget) begin
                    statusCount_ff <= '0;
                    writeFlag_ff <= 1'b1;
                end else begin
                    statusCount_ff <= statusCount_ff + 8'h01;
                end
            end
        end
    end

    // error flag when no room at all
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            errorFlag_ff <= 1'b0;
        end else if (state_ff == S_CHECK && room == 16'h0000) begin
            errorFlag_ff <= 1'b1;
        end else if (busWrite_ff && busAddr_ff == ADDR_DMA_STATUS && hwdata[STATUS_ERROR_BIT]) begin
            errorFlag_ff <= 1'b0;
        end
    end

    assign doneWriteFlag = writeFlag_ff;
    assign doneWriteErrorFlag = errorFlag_ff;
endmodule
`default_nettype wire

/* File: include/rx_done_pkg.sv */
// Operation
// - Done FIFO holds up to eight 32-bit descriptor words.
// - Burst mode waits for six entries, then burst-writes the FIFO.
// - Burst writes only as many entries as the queue can hold.
// - No room at all sets write-error flag; no write, pointer unchanged.
// - Successful burst advances write pointer and raises write flag per threshold.
// - Flush timer is a 16-bit down-counter ticking every 256 clocks.
// - Flush timer only matters while burst mode is enabled.
// - Every done-queue write reloads the flush timer.
// - Reload value 0001h is one tick, FFFFh maximum, zero illegal reset value.
// - Bit 4 clear writes singly; set uses FIFO burst writing.
// - Flush bit 5 empties the FIFO; host clears it afterwards.
// - Status threshold bits 8-10 delay write flag to 2^n writes.
// - Config RAM is three words for 40 channels; host writes dword2 low.
// - Per channel keep buffer address, current and starting descriptor offsets.
// - Channel enable bit 0 turns reception on for that channel.
// - Buffer select 00 large, 01 small, 10 small then large, 11 illegal.
// - Buffer offset shifts first-buffer data start by 0 to 15 bytes.
// - Threshold 000 reports at packet end, else after that many buffers; at 000 the 3-bit count also reports every 8th buffer.
// - Reserved bits 10-14 read as any value; host writes zero.
// - First-buffer flag bit 15 set while filling first buffer; drives policy 10.
// - Write pointer advances one word, wraps to 0000h past end address.
// - Queue empty when pointers equal, full when read is one ahead.
package rx_done_pkg;
    localparam logic [11:0] ADDR_BASE0 = 12'h730;
    localparam logic [11:0] ADDR_BASE1 = 12'h734;
    localparam logic [11:0] ADDR_END = 12'h738;
    localparam logic [11:0] ADDR_RDPTR = 12'h73C;
    localparam logic [11:0] ADDR_WRPTR = 12'h740;
    localparam logic [11:0] ADDR_FLUSH_TIMER = 12'h744;
    localparam logic [11:0] ADDR_CHAN_SEL = 12'h770;
    localparam logic [11:0] ADDR_CHAN_DATA = 12'h774;
    localparam logic [11:0] ADDR_QUEUE_CTRL = 12'h780;
    localparam logic [11:0] ADDR_DMA_STATUS = 12'h790;
    localparam int CTRL_BURST_BIT = 4;
    localparam int CTRL_FLUSH_BIT = 5;
    localparam int CTRL_THR_LSB = 8;
    localparam logic [15:0] CTRL_WMASK = 16'h073D;
    localparam logic [15:0] TIMER_RESET = 16'h0000;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam int FIFO_DEPTH = 8;
    localparam int HIGH_WATER = 6;
    localparam int PRESCALE = 256;
    localparam int NUM_CHANNELS = 40;
    localparam int STATUS_WRITE_BIT = 0;
    localparam int STATUS_ERROR_BIT = 1;
    localparam int FBF_BIT = 15;
    localparam logic [15:0] CFG_HOST_MASK = 16'h03FF;

    typedef struct packed {
        logic [5:0] channel;
        logic [15:0] descPtr;
    } done_req_s;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
    } mem_wr_s;

    typedef enum logic [1:0] {BUF_LARGE, BUF_SMALL, BUF_SMALL_LARGE, BUF_ILLEGAL} buf_sel_e;
endpackage

/* File: test/done_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module done_mem_model
    import rx_done_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Write port from the engine
    input wire rx_done_pkg::mem_wr_s memWr,
    output logic memReady,
    // Wait states before each accept, zero answers at once
    input wire logic [3:0] stall
);
    import rx_done_pkg::*;
    logic [3:0] waitCnt_ff;
    logic [31:0] nWrites_ff;
    logic [31:0] addrLog_ff [64];
    logic [31:0] dataLog_ff [64];
    assign memReady = memWr.valid && waitCnt_ff >= stall;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            waitCnt_ff <= 4'h0;
            nWrites_ff <= 32'h0000_0000;
        end else if (memReady) begin
            addrLog_ff[nWrites_ff[5:0]] <= memWr.addr;
            dataLog_ff[nWrites_ff[5:0]] <= memWr.data;
            nWrites_ff <= nWrites_ff + 32'h0000_0001;
            waitCnt_ff <= 4'h0;
        end else if (memWr.valid) begin
            waitCnt_ff <= waitCnt_ff + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* File: test/rx_done_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_done_monitor
    import rx_done_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int WATERMARK = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register bus
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Queue side
    input wire logic doneValid,
    input wire logic doneReady,
    input wire rx_done_pkg::mem_wr_s memWr,
    input wire logic memReady,
    input wire logic doneWriteFlag,
    input wire logic doneWriteErrorFlag
);
    logic wrPhase_ff, burstOn_ff, takeAddr, statusWr;
    logic [11:0] wrAddr_ff;
    assign takeAddr = hsel && htrans[1] && hready;
    assign statusWr = wrPhase_ff && wrAddr_ff == ADDR_DMA_STATUS;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPhase_ff <= 1'b0;
            wrAddr_ff <= 12'h000;
        end else begin
            wrPhase_ff <= takeAddr && hwrite;
            wrAddr_ff <= haddr;
        end
    end

    // Flush bit is lumped with the burst bit here, so a set flush bit also exempts descriptors from the single-write check
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            burstOn_ff <= 1'b0;
        end else if (wrPhase_ff && wrAddr_ff == ADDR_QUEUE_CTRL) begin
            burstOn_ff <= hwdata[CTRL_BURST_BIT] || hwdata[CTRL_FLUSH_BIT];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence descTaken;
        doneValid && doneReady && !burstOn_ff;
    endsequence
    sequence memStall;
        memWr.valid && !memReady;
    endsequence

    single_write_a: assert property (descTaken |-> ##[1:40] (memWr.valid || doneWriteErrorFlag))
        else $error("single descriptor not written");
    mem_hold_a: assert property (memStall |=> memWr.valid && $stable(memWr.addr) && $stable(memWr.data))
        else $error("memory write dropped before accept");
    word_align_a: assert property (memWr.valid |-> memWr.addr[1:0] == 2'b00)
        else $error("done queue address not word aligned");
    err_sticky_a: assert property (doneWriteErrorFlag && !statusWr |=> doneWriteErrorFlag)
        else $error("error flag cleared without host write");
    flag_sticky_a: assert property (doneWriteFlag && !statusWr |=> doneWriteFlag)
        else $error("write flag cleared without host write");
    bus_ready_a: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    rdata_hold_a: assert property (!(takeAddr && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a read");
    reset_quiet_a: assert property (@(posedge clk) disable iff (1'b0)
        !resetn ##1 !resetn |-> !memWr.valid && !doneWriteFlag && !doneWriteErrorFlag)
        else $error("outputs active during reset");
endmodule

bind rx_done_queue_burst_dma rx_done_monitor #(.DEPTH(DEPTH), .WATERMARK(WATERMARK)) i_rx_done_monitor (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .doneValid(doneValid), .doneReady(doneReady), .memWr(memWr), .memReady(memReady),
    .doneWriteFlag(doneWriteFlag), .doneWriteErrorFlag(doneWriteErrorFlag)
);
`default_nettype wire

/* File: test/rx_done_queue_burst_dma_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_done_queue_burst_dma_bench;
    import rx_done_pkg::*;
    localparam logic [31:0] BASE = 32'h0002_1000;
    logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp, doneValid, doneReady;
    logic viewEnable, viewUseSmall, memReady, doneWriteFlag, doneWriteErrorFlag, fillDone;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, viewStartAddr, q;
    logic [5:0] viewChannel;
    logic [3:0] stall;
    done_req_s doneReq;
    mem_wr_s memWr;
    int n_errors, compares;
    wire [31:0] nW = i_done_mem_model.nWrites_ff;
    assign hready = hreadyout;

    rx_done_queue_burst_dma i_rx_done_queue_burst_dma (
        .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .doneReq(doneReq), .doneValid(doneValid), .doneReady(doneReady),
        .fillChannel(6'h05), .fillBufferDone(fillDone), .fillPacketEnd(1'b1),
        .fillNextAddr(32'h0000_0100), .fillNextDesc(16'h0000), .viewChannel(viewChannel),
        .viewEnable(viewEnable), .viewUseSmall(viewUseSmall), .viewStartAddr(viewStartAddr),
        .memWr(memWr), .memReady(memReady), .doneWriteFlag(doneWriteFlag),
        .doneWriteErrorFlag(doneWriteErrorFlag)
    );
    done_mem_model i_done_mem_model (
        .clk(clk), .resetn(resetn), .memWr(memWr), .memReady(memReady), .stall(stall)
    );

    always #2.5 clk = ~clk;

    task automatic final_report;
        if (n_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(q, exp);
    endtask

    task automatic send(input logic [5:0] ch, input logic [15:0] p);
        doneReq <= '{channel: ch, descPtr: p};
        doneValid <= 1'b1;
        do @(negedge clk); while (doneReady !== 1'b1);
        @(posedge clk);
        doneValid <= 1'b0;
        doneReq <= ~doneReq;
        @(posedge clk);
    endtask

    task automatic waitw(input logic [31:0] n, input int lim);
        repeat (lim) begin
            if (nW >= n) break;
            @(posedge clk);
        end
        check(nW, n);
    endtask

    task automatic t_regs;
        rdchk(ADDR_FLUSH_TIMER, 32'h0000_0000);
        rdchk(ADDR_QUEUE_CTRL, 32'h0000_0000);
        bus(1'b1, ADDR_QUEUE_CTRL, 32'h0000_C700);
        rdchk(ADDR_QUEUE_CTRL, 32'h0000_0700);
        rdchk(12'h7F0, 32'h0000_0000);
        bus(1'b1, ADDR_QUEUE_CTRL, 32'h0000_0000);
        bus(1'b1, ADDR_BASE0, 32'h0000_1000);
        bus(1'b1, ADDR_BASE1, 32'h0000_0002);
        bus(1'b1, ADDR_END, 32'h0000_00FF);
    endtask

    task automatic t_single;
        send(6'd3, 16'h1234);
        waitw(1, 50);
        check(i_done_mem_model.addrLog_ff[0], BASE);
        check(i_done_mem_model.dataLog_ff[0] & 32'h80FF_FFFF, 32'h0003_1234);
        rdchk(ADDR_WRPTR, 32'h0000_0001);
        check({31'd0, doneWriteFlag}, 32'h0000_0001);
        bus(1'b1, ADDR_DMA_STATUS, 32'h0000_0003);
        @(posedge clk);
        check({31'd0, doneWriteFlag}, 32'h0000_0000);
    endtask

    task automatic t_burst;
        stall <= 4'd3;
        bus(1'b1, ADDR_FLUSH_TIMER, 32'h0000_FFFF);
        bus(1'b1, ADDR_QUEUE_CTRL, 32'h0000_0010);
        for (int i = 0; i < 5; i++) send(i[5:0], 16'h0100 + i[15:0]);
        repeat (40) @(posedge clk);
        check(nW, 32'h0000_0001);
        send(6'd5, 16'h0105);
        waitw(32'h0000_0007, 200);
        for (int i = 1; i < 7; i++) check(i_done_mem_model.addrLog_ff[i], BASE + 32'(4 * i));
        rdchk(ADDR_WRPTR, 32'h0000_0007);
    endtask

    task automatic t_room;
        bus(1'b1, ADDR_RDPTR, 32'h0000_000A);
        for (int i = 0; i < 6; i++) send(6'd7, 16'h0200 + i[15:0]);
        repeat (40) @(posedge clk);
        check(nW, 32'h0000_0009);
        rdchk(ADDR_WRPTR, 32'h0000_0009);
        bus(1'b1, ADDR_RDPTR, 32'h0000_0020);
        bus(1'b1, ADDR_FLUSH_TIMER, 32'h0000_0002);
        bus(1'b1, ADDR_QUEUE_CTRL, 32'h0000_0030);
        waitw(32'h0000_000D, 100);
        bus(1'b1, ADDR_QUEUE_CTRL, 32'h0000_0010);
        send(6'd8, 16'h0300);
        repeat (200) @(posedge clk);
        check(nW, 32'h0000_000D);
        waitw(32'h0000_000E, 800);
    endtask

    task automatic t_thresh;
        stall <= 4'd0;
        bus(1'b1, ADDR_QUEUE_CTRL, 32'h0000_0100);
        bus(1'b1, ADDR_DMA_STATUS, 32'h0000_0003);
        send(6'd1, 16'h0400);
        waitw(32'h0000_000F, 50);
        repeat (2) @(posedge clk);
        check({31'd0, doneWriteFlag}, 32'h0000_0000);
        send(6'd1, 16'h0401);
        waitw(32'h0000_0010, 50);
        repeat (2) @(posedge clk);
        check({31'd0, doneWriteFlag}, 32'h0000_0001);
    endtask

    task automatic t_cfg;
        viewChannel <= 6'd5;
        fillDone <= 1'b1;
        @(posedge clk);
        fillDone <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, ADDR_CHAN_SEL, 32'h0000_0405);
            bus(1'b1, ADDR_CHAN_DATA, k ? 32'h0000_0000 : 32'h0000_0093);
            q = 32'h0000_8000;
            for (int i = 0; i < 50 && q[15]; i++) bus(1'b0, ADDR_CHAN_SEL, 32'h0000_0000);
            check({31'd0, viewEnable}, k ? 32'h0000_0000 : 32'h0000_0001);
            check({31'd0, viewUseSmall}, k ? 32'h0000_0000 : 32'h0000_0001);
            check(viewStartAddr, k ? 32'h0000_0100 : 32'h0000_0102);
        end
    endtask

    task automatic t_full;
        bus(1'b1, ADDR_QUEUE_CTRL, 32'h0000_0000);
        bus(1'b1, ADDR_RDPTR, 32'h0000_0011);
        send(6'd2, 16'h0500);
        repeat (40) @(posedge clk);
        check(nW, 32'h0000_0010);
        check({31'd0, doneWriteErrorFlag}, 32'h0000_0001);
        rdchk(ADDR_WRPTR, 32'h0000_0010);
    endtask

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        doneReq = '0;
        doneValid = 1'b0;
        viewChannel = 6'h00;
        fillDone = 1'b0;
        stall = 4'h0;
        n_errors = 0;
        compares = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_regs;
        t_single;
        t_burst;
        t_room;
        t_thresh;
        t_cfg;
        t_full;
        final_report;
    end

    // Whole run is under two thousand cycles; this leaves wide margin
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report;
    end
endmodule
`default_nettype wire
